// file: rtl/wdp_top.sv
`timescale 1ns/1ps
`include "wdp_map.svh"
// Overview of operation
// - three-bit select picks postscale 1:1 to 1:128
// - config enable set: watchdog always runs
// - config enable clear: software bit gates running
// - counts on own rc tick, also asleep
// - time-out while awake requests watchdog reset
// - time-out while asleep wakes, no reset
// - every time-out clears the time-out flag
// - clear or sleep instruction restarts both counts
// - clear zeroes count only, ratio unchanged
// - control bit 0 read/write, bits 7-1 zero
// - config byte: enable bit 0, select bits 3:1
module wdp_top
  import wdp_pkg::*;
#(
  parameter logic [15:0] BASE_TICKS = `WDP_BASE_TICKS,
  parameter logic [7:0] RC_DIV = `WDP_RC_DIV
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire wdp_pkg::wdp_byte_t config_byte_two_high,
  input wire logic watchdog_clear_instruction,
  input wire logic sleep_instruction,
  input wire logic cpu_asleep,
  output logic wd_reset_req,
  output logic wd_wake,
  output logic timeout_status_flag,
  output logic irq
);
  import wdp_pkg::*;

  logic rst_s1_q;
  logic rstn_i;
  logic cfg_loaded_q;
  wdp_byte_t cfg_q;
  logic sw_run_q;
  logic [7:0] rc_div_q;
  logic rc_tick;
  logic run;
  logic clr;
  logic base_roll;
  logic [15:0] base_count;
  logic [6:0] post_q;
  logic timeout;
  logic to_flag_q;
  logic reset_req_q;
  logic wake_q;
  wdp_evt_t evt_stat_q;
  wdp_evt_t evt_en_q;
  wdp_evt_t evt_set;
  wdp_bus_st_t bus_q;
  logic [31:0] rdata_q;
  logic wr_acc;
  logic rd_acc;
  wdp_ps_sel_t ps_sel;
  logic cfg_en;

  // last postscaler count before time-out for a given select code
  function automatic logic [6:0] ps_last(input wdp_ps_sel_t sel);
    ps_last = 7'(({7'h00, 1'b1} << (3'h7 - sel)) - 8'h01);
  endfunction : ps_last

  // reset release through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rstn_i <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rstn_i <= rst_s1_q;
    end
  end

  // fuse byte is caught once after release; until then it reads unprogrammed
  always_ff @(posedge clock or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_loaded_q <= 1'b0;
      cfg_q <= `WDP_CFG_RST;
    end else if (!cfg_loaded_q) begin
      cfg_loaded_q <= 1'b1;
      cfg_q <= config_byte_two_high & `WDP_CFG_RST;
    end
  end

  assign cfg_en = cfg_q[`WDP_CFG_EN_BIT];
  assign ps_sel = cfg_q[`WDP_CFG_PS_MSB:`WDP_CFG_PS_LSB];

  // rc oscillator stand-in: runs on the always-on clock, never on the cpu clock
  always_ff @(posedge clock or negedge rstn_i) begin
    if (!rstn_i) begin
      rc_div_q <= 8'h00;
    end else if (rc_tick) begin
      rc_div_q <= 8'h00;
    end else begin
      rc_div_q <= rc_div_q + 8'h01;
    end
  end
  assign rc_tick = (rc_div_q == RC_DIV - 8'h01);

  assign run = cfg_en || sw_run_q;
  assign clr = watchdog_clear_instruction || sleep_instruction;

  wdp_base_counter #(
    .BASE_TICKS(BASE_TICKS)
  ) u_base (
    .clock(clock),
    .rstn_i(rstn_i),
    .rc_tick(rc_tick),
    .run(run),
    .clr(clr),
    .count_q(base_count),
    .roll(base_roll)
  );

  assign timeout = base_roll && (post_q == ps_last(ps_sel));

  // postscaler: clear touches only the count, never cfg_q
  always_ff @(posedge clock or negedge rstn_i) begin
    if (!rstn_i) begin
      post_q <= 7'h00;
    end else if (clr || timeout) begin
      post_q <= 7'h00;
    end else if (base_roll) begin
      post_q <= post_q + 7'h01;
    end
  end

  // reset or wake decision, registered one-cycle pulses
  always_ff @(posedge clock or negedge rstn_i) begin
    if (!rstn_i) begin
      reset_req_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      reset_req_q <= timeout && !cpu_asleep;
      wake_q <= timeout && cpu_asleep;
    end
  end
  assign wd_reset_req = reset_req_q;
  assign wd_wake = wake_q;

  // time-out flag: set by clear/sleep instruction, cleared by a time-out
  always_ff @(posedge clock or negedge rstn_i) begin
    if (!rstn_i) begin
      to_flag_q <= `WDP_TO_FLAG_RST;
    end else if (clr) begin
      to_flag_q <= 1'b1;
    end else if (timeout) begin
      to_flag_q <= 1'b0;
    end
  end
  assign timeout_status_flag = to_flag_q;

  // bus: one wait state, answer at the second edge of a request
  assign wr_acc = avs_write && bus_q == WDP_BUS_ACK;
  assign rd_acc = avs_read && bus_q == WDP_BUS_ACK;
  assign avs_waitrequest = (avs_read || avs_write) && bus_q == WDP_BUS_IDLE;

  always_ff @(posedge clock or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_q <= WDP_BUS_IDLE;
    end else begin
      unique case (bus_q)
        WDP_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= WDP_BUS_ACK;
          end
        end
        WDP_BUS_ACK: begin
          bus_q <= WDP_BUS_IDLE;
        end
      endcase
    end
  end

  // software run bit has no effect on running while cfg_en is set
  always_ff @(posedge clock or negedge rstn_i) begin
    if (!rstn_i) begin
      sw_run_q <= `WDP_SW_CTRL_RST;
    end else if (wr_acc && avs_byteenable[0] && avs_address == `WDP_ADDR_SW_CTRL) begin
      sw_run_q <= avs_writedata[`WDP_SW_RUN_BIT];
    end
  end

  always_ff @(posedge clock or negedge rstn_i) begin
    if (!rstn_i) begin
      evt_en_q <= `WDP_EVT_RST;
    end else if (wr_acc && avs_byteenable[0] && avs_address == `WDP_ADDR_IRQ_EN) begin
      evt_en_q <= avs_writedata[1:0];
    end
  end

  assign evt_set = {wake_q, reset_req_q};

  // sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rstn_i) begin
    if (!rstn_i) begin
      evt_stat_q <= `WDP_EVT_RST;
    end else if (wr_acc && avs_byteenable[0] && avs_address == `WDP_ADDR_IRQ_CLR) begin
      evt_stat_q <= (evt_stat_q & ~avs_writedata[1:0]) | evt_set;
    end else begin
      evt_stat_q <= evt_stat_q | evt_set;
    end
  end
  assign irq = |(evt_stat_q & evt_en_q);

  always_ff @(posedge clock or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && bus_q == WDP_BUS_IDLE) begin
      unique case (avs_address)
        `WDP_ADDR_SW_CTRL: rdata_q <= {31'h0000_0000, sw_run_q};
        `WDP_ADDR_CONFIG: rdata_q <= {24'h00_0000, cfg_q};
        `WDP_ADDR_RST_STAT: rdata_q <= {28'h000_0000, to_flag_q, 3'h0};
        `WDP_ADDR_IRQ_STAT: rdata_q <= {30'h0000_0000, evt_stat_q};
        `WDP_ADDR_IRQ_EN: rdata_q <= {30'h0000_0000, evt_en_q};
        `WDP_ADDR_POST_CNT: rdata_q <= {25'h000_0000, post_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = rdata_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn_i);

  sequence s_timeout_awake;
    timeout && !cpu_asleep;
  endsequence
  sequence s_timeout_asleep;
    timeout && cpu_asleep;
  endsequence

  property p_ratio;
    timeout |-> base_roll && post_q == ps_last(ps_sel);
  endproperty
  a_ratio: assert property (p_ratio) else $error("time-out off ratio");

  property p_post_128;
    ps_sel == 3'h0 && timeout |-> post_q == 7'h7F;
  endproperty
  a_post_128: assert property (p_post_128) else $error("1:128 wrong");

  property p_cfg_run;
    cfg_en |-> run;
  endproperty
  a_cfg_run: assert property (p_cfg_run) else $error("enabled but stopped");

  property p_sw_stop;
    !cfg_en && !sw_run_q |=> $stable(base_count) || base_count == 16'h0000;
  endproperty
  a_sw_stop: assert property (p_sw_stop) else $error("counts while off");

  property p_sleep_count;
    cpu_asleep && run && rc_tick && !clr && !base_roll |=> base_count != $past(base_count);
  endproperty
  a_sleep_count: assert property (p_sleep_count) else $error("stalled in sleep");

  property p_reset;
    s_timeout_awake |=> wd_reset_req && !wd_wake ##1 !wd_reset_req;
  endproperty
  a_reset: assert property (p_reset) else $error("no watchdog reset");

  property p_wake;
    s_timeout_asleep |=> wd_wake && !wd_reset_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_to_clr;
    timeout |=> !timeout_status_flag;
  endproperty
  a_to_clr: assert property (p_to_clr) else $error("flag not cleared");

  property p_clear;
    clr |=> post_q == 7'h00 && base_count == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");

  property p_keep_ratio;
    cfg_loaded_q && watchdog_clear_instruction |=> $stable(ps_sel) && $stable(cfg_en);
  endproperty
  a_keep_ratio: assert property (p_keep_ratio) else $error("ratio changed");

  property p_ctrl_read;
    rd_acc && avs_address == `WDP_ADDR_SW_CTRL |-> avs_readdata[31:1] == 31'h0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("upper bits set");

  property p_cfg_map;
    cfg_loaded_q |-> ps_sel == cfg_q[3:1] && cfg_en == cfg_q[0];
  endproperty
  a_cfg_map: assert property (p_cfg_map) else $error("config map wrong");
endmodule : wdp_top

// file: pkg/wdp_map.svh
`ifndef WDP_MAP_SVH
`define WDP_MAP_SVH
// register byte addresses (word aligned)
`define WDP_ADDR_SW_CTRL 8'h00
`define WDP_ADDR_CONFIG 8'h04
`define WDP_ADDR_RST_STAT 8'h08
`define WDP_ADDR_IRQ_STAT 8'h0C
`define WDP_ADDR_IRQ_CLR 8'h10
`define WDP_ADDR_IRQ_EN 8'h14
`define WDP_ADDR_POST_CNT 8'h18
// field positions
`define WDP_SW_RUN_BIT 0
`define WDP_CFG_EN_BIT 0
`define WDP_CFG_PS_LSB 1
`define WDP_CFG_PS_MSB 3
`define WDP_TO_FLAG_BIT 3
`define WDP_EVT_RESET_BIT 0
`define WDP_EVT_WAKE_BIT 1
// reset values
`define WDP_SW_CTRL_RST 1'h0
`define WDP_CFG_RST 8'h0F
`define WDP_TO_FLAG_RST 1'h1
`define WDP_EVT_RST 2'h0
// config byte location in program space
`define WDP_CFG_BYTE_ADDR 24'h300003
// timing: base period in rc oscillator ticks, main clocks per rc tick
`define WDP_BASE_TICKS 16'h0100
`define WDP_RC_DIV 8'h08
`endif

// file: pkg/wdp_pkg.sv
`include "wdp_map.svh"
package wdp_pkg;
  typedef logic [2:0] wdp_ps_sel_t;
  typedef logic [7:0] wdp_byte_t;
  typedef logic [1:0] wdp_evt_t;
  typedef enum logic {WDP_BUS_IDLE, WDP_BUS_ACK} wdp_bus_st_t;
endpackage : wdp_pkg

// file: rtl/wdp_base_counter.sv
`timescale 1ns/1ps
`include "wdp_map.svh"
module wdp_base_counter #(
  parameter logic [15:0] BASE_TICKS = `WDP_BASE_TICKS
) (
  input wire logic clock,
  input wire logic rstn_i,
  input wire logic rc_tick,
  input wire logic run,
  input wire logic clr,
  output logic [15:0] count_q,
  output logic roll
);
  // roll is suppressed by a clear so a clear always wins over a time-out
  assign roll = rc_tick && run && !clr && (count_q == BASE_TICKS - 16'h0001);

  always_ff @(posedge clock or negedge rstn_i) begin
    if (!rstn_i) begin
      count_q <= 16'h0000;
    end else if (clr || roll) begin
      count_q <= 16'h0000;
    end else if (rc_tick && run) begin
      count_q <= count_q + 16'h0001;
    end
  end
endmodule : wdp_base_counter

// file: bench/wdp_core_model.sv
`timescale 1ns/1ps
module wdp_core_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clr_req,
  input wire logic slp_req,
  input wire logic wd_reset_req,
  input wire logic wd_wake,
  output logic clear_pulse,
  output logic sleep_pulse,
  output logic asleep
);
  // strobes last one cycle, as the core retires one instruction per cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clear_pulse <= 1'b0;
      sleep_pulse <= 1'b0;
    end else begin
      clear_pulse <= clr_req;
      sleep_pulse <= slp_req;
    end
  end
  // only a wake-up or a reset brings the core out of sleep
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      asleep <= 1'b0;
    end else if (wd_wake || wd_reset_req) begin
      asleep <= 1'b0;
    end else if (slp_req) begin
      asleep <= 1'b1;
    end
  end
endmodule : wdp_core_model

// file: bench/testbench.sv
`timescale 1ns/1ps
`include "wdp_map.svh"
module testbench;
  import wdp_pkg::*;
  localparam int BT = 4;
  localparam int RD = 2;
  logic clock, rst_n, avs_read, avs_write, clr_req, slp_req, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, v;
  logic [3:0] avs_byteenable;
  wdp_byte_t cfg;
  logic clear_pulse, sleep_pulse, asleep, wd_reset_req, wd_wake, tflag, irq;
  int fail_count = 0;
  int checks_done = 0;
  int resets_seen = 0;
  int n, snap;
  integer seed;
  wdp_top #(.BASE_TICKS(16'h0004), .RC_DIV(8'h02)) i_dut (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .config_byte_two_high(cfg), .watchdog_clear_instruction(clear_pulse),
    .sleep_instruction(sleep_pulse), .cpu_asleep(asleep), .wd_reset_req(wd_reset_req),
    .wd_wake(wd_wake), .timeout_status_flag(tflag), .irq(irq));
  wdp_core_model i_core (
    .clock(clock), .rst_n(rst_n), .clr_req(clr_req), .slp_req(slp_req),
    .wd_reset_req(wd_reset_req), .wd_wake(wd_wake), .clear_pulse(clear_pulse),
    .sleep_pulse(sleep_pulse), .asleep(asleep));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    if (wd_reset_req === 1'b1) resets_seen <= resets_seen + 1;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // request stands until the edge that sees waitrequest low; data is taken at that edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task rst(input wdp_byte_t c);
    @(posedge clock);
    rst_n <= 1'b0;
    cfg <= c;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask : rst
  task pulse(input logic s);
    @(posedge clock);
    if (s) slp_req <= 1'b1;
    else clr_req <= 1'b1;
    @(posedge clock);
    clr_req <= 1'b0;
    slp_req <= 1'b0;
  endtask : pulse
  task wait_evt(input int lim);
    n = 0;
    while (wd_reset_req !== 1'b1 && wd_wake !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask : wait_evt
  // the rc tick phase is not tied to the clear, so allow one tick plus two clocks of slack either way
  function automatic logic in_win(input int got, input int ratio);
    return got >= ratio * BT * RD - RD - 2 && got <= ratio * BT * RD + RD + 2;
  endfunction : in_win
  initial begin
    #(100 * 40000);
    fail_count++;
    wrap_up();
  end
  initial begin
    seed = 32'h8dd5867b;
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    clr_req = 1'b0;
    slp_req = 1'b0;
    cfg = 8'h0F;
    rst(8'h0F);
    bus(0, `WDP_ADDR_SW_CTRL, 32'h0);
    chk(rd, 32'h0);
    repeat (4) begin
      v = $random(seed);
      bus(1, `WDP_ADDR_SW_CTRL, v);
      bus(0, `WDP_ADDR_SW_CTRL, 32'h0);
      chk(rd, {31'h0, v[0]});
    end
    bus(0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    for (int s = 7; s >= 0; s--) begin
      rst({4'h0, s[2:0], 1'b1});
      bus(0, `WDP_ADDR_CONFIG, 32'h0);
      chk(rd, {28'h0, s[2:0], 1'b1});
      pulse(0);
      wait_evt(3000);
      chk(in_win(n, 1 << (7 - s)), 1'b1);
      chk(wd_reset_req, 1'b1);
      chk(tflag, 1'b0);
    end
    bus(0, `WDP_ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h1);
    chk(irq, 1'b0);
    bus(1, `WDP_ADDR_IRQ_EN, 32'h3);
    @(negedge clock);
    chk(irq, 1'b1);
    bus(0, `WDP_ADDR_IRQ_EN, 32'h0);
    chk(rd, 32'h3);
    bus(1, `WDP_ADDR_IRQ_CLR, 32'h1);
    @(negedge clock);
    chk(irq, 1'b0);
    pulse(0);
    bus(0, `WDP_ADDR_POST_CNT, 32'h0);
    chk(rd, 32'h0);
    chk(tflag, 1'b1);
    bus(0, `WDP_ADDR_RST_STAT, 32'h0);
    chk(rd, 32'h1 << `WDP_TO_FLAG_BIT);
    bus(0, `WDP_ADDR_CONFIG, 32'h0);
    chk(rd, 32'h1);
    rst(8'h0D);
    snap = resets_seen;
    repeat (20) begin
      pulse(0);
      repeat (2 + ($random(seed) & 3)) @(posedge clock);
    end
    chk(resets_seen, snap);
    pulse(1);
    wait_evt(200);
    chk(wd_wake, 1'b1);
    chk(resets_seen, snap);
    chk(in_win(n, 2), 1'b1);
    bus(0, `WDP_ADDR_IRQ_STAT, 32'h0);
    chk(rd[1], 1'b1);
    rst(8'h0F);
    bus(1, `WDP_ADDR_SW_CTRL, 32'h0);
    pulse(0);
    wait_evt(100);
    chk(in_win(n, 1), 1'b1);
    rst(8'h0E);
    pulse(0);
    wait_evt(100);
    chk(n, 100);
    // a write with lane 0 disabled must leave the run bit alone
    @(posedge clock);
    avs_byteenable <= 4'hE;
    bus(1, `WDP_ADDR_SW_CTRL, 32'h1);
    avs_byteenable <= 4'hF;
    bus(0, `WDP_ADDR_SW_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1, `WDP_ADDR_SW_CTRL, 32'h1);
    pulse(0);
    wait_evt(100);
    chk(in_win(n, 1), 1'b1);
    wrap_up();
  end
endmodule : testbench
